// [dtspm_pkg.sv]
/*
  package for the debug, trace and serial pin mux: field positions,
  config codes and reset values. assumes single 50 MHz clock domain.
*/
package dtspm_pkg;
  // gpio config field codes (4-bit per pin)
  localparam logic [3:0] DTSPM_CFG_OUT     = 4'h1;
  localparam logic [3:0] DTSPM_CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] DTSPM_CFG_ALT_OD  = 4'hD;
  localparam logic [3:0] DTSPM_CFG_IN      = 4'h4;
  // field positions
  localparam int DTSPM_A5_LSB   = 4;  // port_a_config_high[7:4]
  localparam int DTSPM_B0_LSB   = 0;  // port_b_config_low[3:0]
  localparam int DTSPM_B1_LSB   = 4;  // port_b_config_low[7:4]
  localparam int DTSPM_B2_LSB   = 8;  // port_b_config_low[11:8]
  localparam int DTSPM_C2_LSB   = 8;  // port_c_config_low[11:8]
  localparam int DTSPM_C3_LSB   = 12; // port_c_config_low[15:12]
  localparam int DTSPM_C4_LSB   = 0;  // port_c_config_low[3:0]
  localparam int DTSPM_DBG_GPIO = 5;  // debug_pin_config[5]
  // serial controller 1 modes
  localparam logic [1:0] DTSPM_SER_OFF  = 2'h0;
  localparam logic [1:0] DTSPM_SER_UART = 2'h1;
  localparam logic [1:0] DTSPM_SER_SPI  = 2'h2;
  // reset values
  localparam logic DTSPM_SW_MODE_RST = 1'b0;  // jtag after reset
  localparam logic DTSPM_STRAP_RST   = 1'b0;
  localparam logic DTSPM_SYNC_RST    = 1'b0;
endpackage

// [dtspm_sync.sv]
/*
  two-flop synchroniser for one pin input.
  assumes the input is asynchronous to clk.
*/
`timescale 1ns/100ps
module dtspm_sync
  import dtspm_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= DTSPM_SYNC_RST;
      q      <= DTSPM_SYNC_RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// [dtspm_pin_mux.sv]
/*
  pin function selection for port a bit 5, port b bits 0..2, the debug clock
  pin and port c bits 2..4. assumes config fields, debug mode and peripheral
  outputs come from logic on clk; pin inputs are asynchronous.
*/
`timescale 1ns/100ps
// Operation
// - port a bit 5 alternate output is packet trace data or cpu trace bit 3.
// - boot-monitor strap sampled once, at the third edge after reset release; low selects boot monitor.
// - port b bit 1 alternate output is spi slave out or uart tx, by serial mode.
// - port b bit 2 input feeds spi slave in or uart rx, by serial mode.
// - debug port is jtag after reset; debugger may switch to serial wire.
// - debug clock pin is serial wire clock or jtag test clock by mode.
// - port c bits 2 and 4 are gpio only when debug config bit 5 is set.
// - port c bit 3 is gpio when debug config bit 5 set or serial wire active.
// - port c bit 2 outputs async trace in serial wire mode when trace and config select.
// - port b bit 0 outputs cpu trace clock when trace enabled and config selects alternate.
// - port c bit 4 carries bidirectional serial wire data in serial wire mode.
// - port b bit 0 input always feeds external interrupt source a.
module dtspm_pin_mux
  import dtspm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  // configuration
  input  wire logic [15:0] port_a_config_high,
  input  wire logic [15:0] port_b_config_low,
  input  wire logic [15:0] port_c_config_low,
  input  wire logic [7:0]  debug_pin_config,
  input  wire logic        cpu_trace_en,
  input  wire logic        cpu_trace_async,
  input  wire logic [1:0]  ser1_mode_select,
  input  wire logic        ser1_spi_control,
  input  wire logic        sw_switch_req,
  input  wire logic        sw_switch_to_sw,
  // gpio data from the port registers
  input  wire logic        gpio_a5_out,
  input  wire logic        gpio_b0_out,
  input  wire logic        gpio_b1_out,
  input  wire logic        gpio_b2_out,
  input  wire logic        gpio_c2_out,
  input  wire logic        gpio_c3_out,
  input  wire logic        gpio_c4_out,
  // peripheral signals toward the pins
  input  wire logic        packet_trace_data,
  input  wire logic        cpu_trace_bit3,
  input  wire logic        cpu_trace_clock,
  input  wire logic        ser1_slave_out,
  input  wire logic        ser1_uart_tx,
  input  wire logic        jtag_data_out,
  input  wire logic        jtag_data_out_en,
  input  wire logic        sw_trace_out,
  input  wire logic        swdio_out,
  input  wire logic        swdio_out_en,
  // pins
  input  wire logic        port_a_bit5_i,
  input  wire logic        port_b_bit0_i,
  input  wire logic        port_b_bit2_i,
  input  wire logic        port_c_bit3_i,
  input  wire logic        port_c_bit4_i,
  input  wire logic        dbg_clk_pin_i,
  output logic             port_a_bit5_o,
  output logic             port_a_bit5_oe,
  output logic             port_b_bit0_o,
  output logic             port_b_bit0_oe,
  output logic             port_b_bit1_o,
  output logic             port_b_bit1_oe,
  output logic             port_b_bit2_o,
  output logic             port_b_bit2_oe,
  output logic             port_c_bit2_o,
  output logic             port_c_bit2_oe,
  output logic             port_c_bit3_o,
  output logic             port_c_bit3_oe,
  output logic             port_c_bit4_o,
  output logic             port_c_bit4_oe,
  // toward the core
  output logic             boot_monitor_sel,
  output logic             sw_mode_active,
  output logic             ext_irq_a,
  output logic             ser1_slave_in,
  output logic             ser1_uart_rx,
  output logic             jtag_test_clock,
  output logic             sw_clock,
  output logic             jtag_data_in,
  output logic             jtag_mode_select,
  output logic             swdio_in,
  output logic             gpio_in_a5,
  output logic             gpio_in_b0,
  output logic             gpio_in_b2,
  output logic             gpio_in_c3,
  output logic             gpio_in_c4
);
  logic [3:0] a5_cfg;
  logic [3:0] b0_cfg;
  logic [3:0] b1_cfg;
  logic [3:0] b2_cfg;
  logic [3:0] c2_cfg;
  logic [3:0] c3_cfg;
  logic [3:0] c4_cfg;
  logic       a5_s;
  logic       b0_s;
  logic       b2_s;
  logic       c3_s;
  logic       c4_s;
  logic       dclk_s;
  logic       dbg_gpio;
  logic       sw_mode_q;
  logic       strap_q;
  logic       strap_done_q;
  logic [1:0] strap_arm_q;
  logic       a5_alt;
  logic       b0_alt;
  logic       b1_alt;
  logic       c2_alt;

  // config field decode
  assign a5_cfg   = port_a_config_high[DTSPM_A5_LSB +: 4];
  assign b0_cfg   = port_b_config_low[DTSPM_B0_LSB +: 4];
  assign b1_cfg   = port_b_config_low[DTSPM_B1_LSB +: 4];
  assign b2_cfg   = port_b_config_low[DTSPM_B2_LSB +: 4];
  assign c2_cfg   = port_c_config_low[DTSPM_C2_LSB +: 4];
  assign c3_cfg   = port_c_config_low[DTSPM_C3_LSB +: 4];
  assign c4_cfg   = port_c_config_low[DTSPM_C4_LSB +: 4];
  assign dbg_gpio = debug_pin_config[DTSPM_DBG_GPIO];
  assign a5_alt   = (a5_cfg == DTSPM_CFG_ALT_OUT) || (a5_cfg == DTSPM_CFG_ALT_OD);
  assign b0_alt   = (b0_cfg == DTSPM_CFG_ALT_OUT) || (b0_cfg == DTSPM_CFG_ALT_OD);
  assign b1_alt   = (b1_cfg == DTSPM_CFG_ALT_OUT) || (b1_cfg == DTSPM_CFG_ALT_OD);
  assign c2_alt   = (c2_cfg == DTSPM_CFG_ALT_OUT) || (c2_cfg == DTSPM_CFG_ALT_OD);

  // pin input synchronisers
  dtspm_sync u_a5 (.clk(clk), .nrst(nrst), .d(port_a_bit5_i), .q(a5_s));
  dtspm_sync u_b0 (.clk(clk), .nrst(nrst), .d(port_b_bit0_i), .q(b0_s));
  dtspm_sync u_b2 (.clk(clk), .nrst(nrst), .d(port_b_bit2_i), .q(b2_s));
  dtspm_sync u_c3 (.clk(clk), .nrst(nrst), .d(port_c_bit3_i), .q(c3_s));
  dtspm_sync u_c4 (.clk(clk), .nrst(nrst), .d(port_c_bit4_i), .q(c4_s));
  dtspm_sync u_dck (.clk(clk), .nrst(nrst), .d(dbg_clk_pin_i), .q(dclk_s));

  // debug mode: jtag on reset, debugger switch sequence sets serial wire
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_mode_q <= DTSPM_SW_MODE_RST;
    end else if (sw_switch_req) begin
      sw_mode_q <= sw_switch_to_sw;
    end
  end

  // strap capture: the synchroniser still holds its reset value for two edges
  // after release, so the pin is taken at the third edge and then frozen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_arm_q  <= 2'h0;
      strap_q      <= DTSPM_STRAP_RST;
      strap_done_q <= 1'b0;
    end else begin
      strap_arm_q <= {strap_arm_q[0], 1'b1};
      if (strap_arm_q[1] && !strap_done_q) begin
        strap_q      <= ~a5_s;  // active-low strap
        strap_done_q <= 1'b1;
      end
    end
  end
  assign boot_monitor_sel = strap_q;
  assign sw_mode_active   = sw_mode_q;

  // port a bit 5 output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_a_bit5_o  <= 1'b0;
      port_a_bit5_oe <= 1'b0;
    end else if (a5_alt) begin
      port_a_bit5_o  <= cpu_trace_en ? cpu_trace_bit3 : packet_trace_data;
      port_a_bit5_oe <= 1'b1;
    end else begin
      port_a_bit5_o  <= gpio_a5_out;
      port_a_bit5_oe <= (a5_cfg == DTSPM_CFG_OUT);
    end
  end

  // port b bit 0 output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_b_bit0_o  <= 1'b0;
      port_b_bit0_oe <= 1'b0;
    end else if (b0_alt && cpu_trace_en) begin
      port_b_bit0_o  <= cpu_trace_clock;
      port_b_bit0_oe <= 1'b1;
    end else begin
      port_b_bit0_o  <= gpio_b0_out;
      port_b_bit0_oe <= (b0_cfg == DTSPM_CFG_OUT);
    end
  end

  // port b bit 1 output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_b_bit1_o  <= 1'b0;
      port_b_bit1_oe <= 1'b0;
    end else if (b1_alt && ser1_mode_select == DTSPM_SER_SPI && ser1_spi_control) begin
      port_b_bit1_o  <= ser1_slave_out;
      port_b_bit1_oe <= 1'b1;
    end else if (b1_alt && ser1_mode_select == DTSPM_SER_UART) begin
      port_b_bit1_o  <= ser1_uart_tx;
      port_b_bit1_oe <= 1'b1;
    end else begin
      port_b_bit1_o  <= gpio_b1_out;
      port_b_bit1_oe <= (b1_cfg == DTSPM_CFG_OUT);
    end
  end

  // port b bit 2 stays a gpio on output; its input feeds serial 1
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_b_bit2_o  <= 1'b0;
      port_b_bit2_oe <= 1'b0;
    end else begin
      port_b_bit2_o  <= gpio_b2_out;
      port_b_bit2_oe <= (b2_cfg == DTSPM_CFG_OUT);
    end
  end

  // port c bit 2: gpio, async trace or jtag data out
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_c_bit2_o  <= 1'b0;
      port_c_bit2_oe <= 1'b0;
    end else if (dbg_gpio) begin
      port_c_bit2_o  <= gpio_c2_out;
      port_c_bit2_oe <= (c2_cfg == DTSPM_CFG_OUT);
    end else if (sw_mode_q) begin
      port_c_bit2_o  <= sw_trace_out;
      port_c_bit2_oe <= cpu_trace_en && cpu_trace_async && c2_alt;
    end else begin
      port_c_bit2_o  <= jtag_data_out;
      port_c_bit2_oe <= jtag_data_out_en;
    end
  end

  // port c bit 3: gpio unless jtag owns it as data in
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_c_bit3_o  <= 1'b0;
      port_c_bit3_oe <= 1'b0;
    end else if (dbg_gpio || sw_mode_q) begin
      port_c_bit3_o  <= gpio_c3_out;
      port_c_bit3_oe <= (c3_cfg == DTSPM_CFG_OUT);
    end else begin
      port_c_bit3_o  <= 1'b0;  // input only in jtag mode
      port_c_bit3_oe <= 1'b0;
    end
  end

  // port c bit 4: gpio, serial wire data or jtag mode select input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_c_bit4_o  <= 1'b0;
      port_c_bit4_oe <= 1'b0;
    end else if (dbg_gpio) begin
      port_c_bit4_o  <= gpio_c4_out;
      port_c_bit4_oe <= (c4_cfg == DTSPM_CFG_OUT);
    end else if (sw_mode_q) begin
      port_c_bit4_o  <= swdio_out;
      port_c_bit4_oe <= swdio_out_en;
    end else begin
      port_c_bit4_o  <= 1'b0;
      port_c_bit4_oe <= 1'b0;
    end
  end

  // inputs toward core, registered after synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_irq_a        <= 1'b0;
      ser1_slave_in    <= 1'b0;
      ser1_uart_rx     <= 1'b1;
      jtag_test_clock  <= 1'b0;
      sw_clock         <= 1'b0;
      jtag_data_in     <= 1'b1;
      jtag_mode_select <= 1'b1;
      swdio_in         <= 1'b1;
      gpio_in_a5       <= 1'b0;
      gpio_in_b0       <= 1'b0;
      gpio_in_b2       <= 1'b0;
      gpio_in_c3       <= 1'b0;
      gpio_in_c4       <= 1'b0;
    end else begin
      ext_irq_a        <= b0_s;
      ser1_slave_in    <= (ser1_mode_select == DTSPM_SER_SPI) && ser1_spi_control && b2_s;
      ser1_uart_rx     <= (ser1_mode_select == DTSPM_SER_UART) ? b2_s : 1'b1;
      jtag_test_clock  <= !sw_mode_q && dclk_s;
      sw_clock         <= sw_mode_q && dclk_s;
      jtag_data_in     <= (dbg_gpio || sw_mode_q) ? 1'b1 : c3_s;
      jtag_mode_select <= (dbg_gpio || sw_mode_q) ? 1'b1 : c4_s;
      swdio_in         <= (!dbg_gpio && sw_mode_q) ? c4_s : 1'b1;
      gpio_in_a5       <= a5_s;
      gpio_in_b0       <= b0_s;
      gpio_in_b2       <= b2_s;
      gpio_in_c3       <= c3_s;
      gpio_in_c4       <= c4_s;
    end
  end
endmodule

// [dtspm_pin_mux_checker.sv]
/*
  assertion checker for the debug, trace and serial pin mux.
  assumes it is bound into dtspm_pin_mux and sees only its ports.
*/
`timescale 1ns/100ps
module dtspm_pin_mux_checker
  import dtspm_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] port_a_config_high,
  input wire logic        cpu_trace_en,
  input wire logic        packet_trace_data,
  input wire logic        cpu_trace_bit3,
  input wire logic        gpio_a5_out,
  input wire logic        port_a_bit5_o,
  input wire logic        port_a_bit5_oe,
  input wire logic        sw_switch_req,
  input wire logic        sw_switch_to_sw,
  input wire logic        sw_mode_active,
  input wire logic        port_b_bit0_i,
  input wire logic        ext_irq_a,
  input wire logic        boot_monitor_sel
);
  logic [2:0] up_q;
  // cycles since reset release, saturating at four
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) up_q <= 3'h0;
    else if (up_q != 3'h4) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // port a bit 5 legs follow their source one cycle later
  property p_a5_pkt;
    port_a_config_high[7:4] == DTSPM_CFG_ALT_OUT && !cpu_trace_en
      |=> port_a_bit5_oe && port_a_bit5_o == $past(packet_trace_data);
  endproperty
  a_a5_pkt: assert property (p_a5_pkt) else $error("port a bit 5 packet leg wrong");
  property p_a5_trc;
    port_a_config_high[7:4] == DTSPM_CFG_ALT_OUT && cpu_trace_en
      |=> port_a_bit5_oe && port_a_bit5_o == $past(cpu_trace_bit3);
  endproperty
  a_a5_trc: assert property (p_a5_trc) else $error("port a bit 5 trace leg wrong");
  property p_a5_gpio;
    port_a_config_high[7:4] == DTSPM_CFG_OUT
      |=> port_a_bit5_oe && port_a_bit5_o == $past(gpio_a5_out);
  endproperty
  a_a5_gpio: assert property (p_a5_gpio) else $error("port a bit 5 gpio leg wrong");
  property p_a5_in; port_a_config_high[7:4] == DTSPM_CFG_IN |=> !port_a_bit5_oe; endproperty
  a_a5_in: assert property (p_a5_in) else $error("port a bit 5 driven as input");
  // debug mode changes only on a switch pulse
  property p_sw_set; sw_switch_req |=> sw_mode_active == $past(sw_switch_to_sw); endproperty
  a_sw_set: assert property (p_sw_set) else $error("debug mode not switched");
  property p_sw_hold; !sw_switch_req |=> $stable(sw_mode_active); endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("debug mode moved alone");
  // interrupt input three cycles behind its pin, strap frozen after release
  property p_irq; up_q >= 3'h3 |-> ext_irq_a == $past(port_b_bit0_i, 3); endproperty
  a_irq: assert property (p_irq) else $error("irq a latency wrong");
  property p_boot; up_q == 3'h4 |-> $stable(boot_monitor_sel); endproperty
  a_boot: assert property (p_boot) else $error("boot select moved");
endmodule
bind dtspm_pin_mux dtspm_pin_mux_checker i_chk (.clk, .nrst, .port_a_config_high,
  .cpu_trace_en, .packet_trace_data, .cpu_trace_bit3, .gpio_a5_out, .port_a_bit5_o,
  .port_a_bit5_oe, .sw_switch_req, .sw_switch_to_sw, .sw_mode_active, .port_b_bit0_i,
  .ext_irq_a, .boot_monitor_sel);

// [dtspm_peer.sv]
/*
  debugger and serial peer model: drives the mux pins.
  assumes the bench supplies the wanted levels; want[6] = debugger drives swdio.
*/
`timescale 1ns/100ps
module dtspm_peer (
  input  wire logic [6:0] want,
  input  wire logic       port_c_bit4_o,
  input  wire logic       port_c_bit4_oe,
  output logic            port_a_bit5_i,
  output logic            port_b_bit0_i,
  output logic            port_b_bit2_i,
  output logic            port_c_bit3_i,
  output logic            port_c_bit4_i,
  output logic            dbg_clk_pin_i
);
  // strap, interrupt, serial data, jtag data and debug clock levels
  assign port_a_bit5_i = want[0];
  assign port_b_bit0_i = want[1];
  assign port_b_bit2_i = want[2];
  assign port_c_bit3_i = want[3];
  assign dbg_clk_pin_i = want[4];
  // swdio wire: mux, else debugger, else the pull-up
  assign port_c_bit4_i = port_c_bit4_oe ? port_c_bit4_o : (want[6] ? want[5] : 1'b1);
endmodule

// [tb.sv]
/*
  testbench for the debug, trace and serial pin mux.
  assumes the peer model drives the pins and the checker is bound in.
*/
`timescale 1ns/100ps
module tb
  import dtspm_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] port_a_config_high, port_b_config_low, port_c_config_low, pat = 16'h0;
  logic [7:0]  debug_pin_config;
  logic [6:0]  want;
  logic [1:0]  ser1_mode_select;
  logic cpu_trace_en, cpu_trace_async, ser1_spi_control, sw_switch_req, sw_switch_to_sw;
  logic swdio_out_en, gpio_a5_out, gpio_b0_out, gpio_b1_out, gpio_b2_out, gpio_c2_out;
  logic gpio_c3_out, gpio_c4_out, packet_trace_data, cpu_trace_bit3, cpu_trace_clock;
  logic ser1_slave_out, ser1_uart_tx, jtag_data_out, jtag_data_out_en, sw_trace_out;
  logic swdio_out, port_a_bit5_i, port_b_bit0_i, port_b_bit2_i, port_c_bit3_i, port_c_bit4_i;
  logic dbg_clk_pin_i, port_a_bit5_o, port_a_bit5_oe, port_b_bit0_o, port_b_bit0_oe;
  logic port_b_bit1_o, port_b_bit1_oe, port_c_bit2_o, port_c_bit2_oe, port_c_bit4_o;
  logic port_c_bit4_oe, boot_monitor_sel, sw_mode_active, ext_irq_a, ser1_slave_in;
  logic ser1_uart_rx, jtag_test_clock, sw_clock, jtag_data_in, jtag_mode_select, swdio_in;
  logic gpio_in_a5, gpio_in_b0, gpio_in_b2, gpio_in_c3, gpio_in_c4;
  logic port_b_bit2_o, port_b_bit2_oe, port_c_bit3_o, port_c_bit3_oe;
  int   n_fail = 0;
  int   samples_checked = 0;
  // core side data changes every cycle so each mux leg shows its own source
  assign {jtag_data_out_en, swdio_out, sw_trace_out, jtag_data_out, ser1_uart_tx,
          ser1_slave_out, cpu_trace_clock, cpu_trace_bit3, packet_trace_data, gpio_c4_out,
          gpio_c3_out, gpio_c2_out, gpio_b2_out, gpio_b1_out, gpio_b0_out,
          gpio_a5_out} = pat;
  always #10 clk = ~clk;
  always @(negedge clk) pat <= pat + 16'h1367;
  dtspm_pin_mux i_dut (.*);
  dtspm_peer i_peer (.want, .port_c_bit4_o, .port_c_bit4_oe, .port_a_bit5_i, .port_b_bit0_i,
    .port_b_bit2_i, .port_c_bit3_i, .port_c_bit4_i, .dbg_clk_pin_i);
  task automatic chk(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %b expected %b", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst(input int n);
    @(negedge clk);
    nrst = 1'b0;
    repeat (n) @(negedge clk);
    nrst = 1'b1;
    cyc(5);
  endtask
  // set every config input but the switch request at a falling edge, then let pins and pads settle
  task automatic setc(input logic [15:0] a, b, c, input logic [7:0] d, input logic [1:0] m,
                      input logic s, te, ta, se, input logic [6:0] w);
    @(negedge clk);
    {port_a_config_high, port_b_config_low, port_c_config_low, debug_pin_config} = {a, b, c, d};
    {ser1_mode_select, ser1_spi_control, cpu_trace_en, cpu_trace_async} = {m, s, te, ta};
    {swdio_out_en, want} = {se, w};
    cyc(5);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {port_a_config_high, port_b_config_low, port_c_config_low} = {16'h0040, 32'h0};
    {debug_pin_config, ser1_mode_select, want, swdio_out_en} = {8'h0, 2'h0, 7'h40, 1'b0};
    {cpu_trace_en, cpu_trace_async, ser1_spi_control, sw_switch_req, sw_switch_to_sw} = '0;
    rst(20);
    chk(boot_monitor_sel, 1'b1);
    chk(sw_mode_active, 1'b0);
    $display("test reset done");
    // jtag mode: uart then spi, packet then cpu trace, pins low then high
    for (int v = 0; v < 2; v++) begin
      setc(16'h0090, 16'h0099, 16'h1000, 8'h0, v ? DTSPM_SER_SPI : DTSPM_SER_UART, v[0], v[0],
           1'b0, 1'b0, {1'b1, {6{v[0]}}});
      chk(port_a_bit5_oe, 1'b1);
      chk(port_a_bit5_o, v ? cpu_trace_bit3 : packet_trace_data);
      chk(port_b_bit1_oe, 1'b1);
      chk(port_b_bit1_o, v ? ser1_slave_out : ser1_uart_tx);
      chk(v ? ser1_slave_in : ser1_uart_rx, want[2]);
      chk(port_b_bit0_o, v ? cpu_trace_clock : gpio_b0_out);
      chk(port_b_bit0_oe, v[0]);
      chk(gpio_in_a5, want[0]);
      chk(gpio_in_b0, want[1]);
      chk(gpio_in_b2, want[2]);
      chk(port_c_bit3_oe, 1'b0);
      chk(port_c_bit3_o, 1'b0);
      chk(ext_irq_a, want[1]);
      chk(jtag_data_in, want[3]);
      chk(jtag_mode_select, want[5]);
      chk(jtag_test_clock, want[4]);
      chk(port_c_bit2_oe, jtag_data_out_en);
    end
    $display("test jtag done");
    // debug pins handed to gpio
    setc(16'h0010, 16'h0100, 16'h1100, 8'h20, DTSPM_SER_OFF, 1'b0, 1'b0, 1'b0, 1'b0, 7'h48);
    chk(port_a_bit5_o, gpio_a5_out);
    chk(port_c_bit2_oe, 1'b1);
    chk(port_c_bit2_o, gpio_c2_out);
    chk(gpio_in_c3, 1'b1);
    chk(port_c_bit3_oe, 1'b1);
    chk(port_c_bit3_o, gpio_c3_out);
    chk(port_c_bit4_o, gpio_c4_out);
    chk(gpio_in_c4, want[5]);
    chk(gpio_in_a5, want[0]);
    chk(port_b_bit2_oe, 1'b1);
    chk(port_b_bit2_o, gpio_b2_out);
    $display("test gpio done");
    // debugger switches to serial wire
    @(negedge clk);
    {sw_switch_req, sw_switch_to_sw} = 2'b11;
    @(negedge clk);
    sw_switch_req = 1'b0;
    chk(sw_mode_active, 1'b1);
    setc(16'h0040, 16'h0, 16'h0900, 8'h0, DTSPM_SER_OFF, 1'b0, 1'b1, 1'b1, 1'b1, 7'h15);
    chk(port_a_bit5_oe, 1'b0);
    chk(port_c_bit2_oe, 1'b1);
    chk(port_c_bit2_o, sw_trace_out);
    chk(port_c_bit4_oe, 1'b1);
    chk(port_c_bit4_o, swdio_out);
    chk(sw_clock, 1'b1);
    chk(gpio_in_c3, 1'b0);
    chk(port_c_bit3_o, gpio_c3_out);
    for (int k = 0; k < 2; k++) begin
      setc(16'h0040, 16'h0, 16'h0900, 8'h0, DTSPM_SER_OFF, 1'b0, 1'b1, 1'b1, 1'b0,
           {1'b1, k[0], 5'h15});
      chk(port_c_bit4_oe, 1'b0);
      chk(swdio_in, k[0]);
    end
    $display("test serial wire done");
    // reset in serial wire mode with the strap released
    rst(3);
    chk(sw_mode_active, 1'b0);
    chk(boot_monitor_sel, 1'b0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
